// File: inc/conv_bank_pkg.sv
// Types shared by the converter, pin and bias register bank
package conv_bank_pkg;

    // Converter sequencer states
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_DONE
    } conv_state_e;

    // Register access request from the serial port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Per-pin drive settings to the pad ring
    typedef struct packed {
        logic [2:0] value;
        logic [2:0] enable;
        logic [2:0] low_volt;
    } pin_drive_s;

endpackage : conv_bank_pkg

// File: inc/conv_bank_regs.svh
// Register offsets, field positions, reset values and timing counts of the bank
`ifndef CONV_BANK_REGS_SVH
`define CONV_BANK_REGS_SVH

// Offsets
`define OFS_CONV_CONTROL 10'h302
`define OFS_CONV_STATUS 10'h303
`define OFS_CONV_RESULT 10'h304
`define OFS_PIN_OUTPUT 10'h305
`define OFS_PIN_INPUT 10'h306
`define OFS_PIN_DIR_LEVEL 10'h307
`define OFS_IF_AMP_BIAS 10'h308
`define OFS_OUT_DRV_BIAS 10'h309
`define OFS_LO_AMP_BIAS 10'h30A
`define OFS_DET_TRIM 10'h30C
`define OFS_MIX_BIAS_POS 10'h30D
`define OFS_MIX_BIAS_NEG 10'h30E

// Reset values
`define RST_CONV_CONTROL 8'hCA
`define RST_CONV_STATUS 8'h01
`define RST_CONV_RESULT 8'hEF
`define RST_PIN_OUTPUT 8'h00
`define RST_PIN_SAMPLED 3'h7
`define RST_PIN_DIR_LEVEL 8'h00
`define RST_IF_AMP_BIAS 8'h08
`define RST_OUT_DRV_BIAS 8'h88
`define RST_LO_AMP_BIAS 8'h88
`define RST_DET_TRIM 8'h00
`define RST_MIX_BIAS 8'h08

// Field positions
`define BIT_CONV_ENABLE 0
`define BIT_CONV_START 1
`define BIT_CONV_HALVE 2
`define BIT_CONV_LOG 3
`define BIT_STAT_EOC 0
`define BIT_STAT_BUSY 1
`define BIT_STAT_READY 2

// Writable masks of mixed-access registers
`define MASK_PIN_OUTPUT 8'h0E
`define MASK_PIN_DIR_LEVEL 8'h7E
`define MASK_IF_AMP_BIAS 8'h0F
`define MASK_5BIT 8'h1F

// Converter clock cycles per conversion
`define CONV_CYCLES 4'h8

`endif

// File: rtl/adc_gpio_bias_regs.sv
// Converter control, general-purpose pins and analog bias register bank
`timescale 1ns/10ps
`default_nettype none
`include "conv_bank_regs.svh"

// Function
// - Converter clock is reference over twice divider
// - Bit 3 selects logarithmic result scale
// - Bit 2 halves converter input
// - Only start bit rising edge starts conversion
// - Ready flag set once result latched
// - Busy while converting, end flag when done
// - Read-only result register resets to 0xEF
// - Output register bits drive the pins
// - Sampled pin levels readable, reset ones
// - Direction bit one makes pin output
// - Level bit selects 3.3 or 1.8 volt
// - Five-bit detector trim, upper bits reserved
module adc_gpio_bias_regs
    import conv_bank_pkg::*;
#(
    parameter int RESULT_W = 8
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire reg_req_s req_in,
    input wire logic ref_tick_in,
    input wire logic [RESULT_W-1:0] sample_in,
    input wire logic [2:0] pin_level_in,
    output logic [7:0] rdata_out,
    output pin_drive_s pin_out,
    output logic conv_log_out,
    output logic conv_halve_out,
    output logic conv_clk_out,
    output logic [3:0] if_amp_bias_level_out,
    output logic [7:0] output_driver_bias_out,
    output logic [7:0] lo_amp_bias_out,
    output logic [4:0] detector_trim_value_out,
    output logic [4:0] mixer_bias_pos_field_out,
    output logic [4:0] mixer_bias_neg_field_out
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] control_reg; // Converter control
    logic [7:0] status_reg; // Converter status
    logic [7:0] result_reg; // Converter result
    logic [7:0] pin_output_reg; // Pin drive values
    logic [2:0] pin_sampled_reg; // Sampled pin levels
    logic [7:0] pin_dir_level_reg; // Direction and level
    logic [7:0] if_bias_reg; // IF amplifier bias
    logic [7:0] drv_bias_reg; // Output driver bias
    logic [7:0] lo_bias_reg; // LO amplifier bias
    logic [7:0] trim_reg; // Detector trim
    logic [7:0] mix_pos_reg; // Mixer bias positive
    logic [7:0] mix_neg_reg; // Mixer bias negative
    logic start_prev_reg; // Start bit last cycle
    logic [3:0] div_count_reg; // Reference tick counter
    logic conv_clk_reg; // Divided converter clock
    logic [3:0] bit_count_reg; // Converter cycles left
    conv_state_e state_reg; // Sequencer state
    logic [7:0] rdata_reg; // Read data holding

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Masked merge of write data into a register
    function automatic logic [7:0] merge(input logic [7:0] old_val,
                                         input logic [7:0] wdata,
                                         input logic [7:0] mask);
        merge = (old_val & ~mask) | (wdata & mask);
    endfunction : merge

    wire wr_control = req_in.wr && (req_in.addr == `OFS_CONV_CONTROL);
    wire wr_pin_out = req_in.wr && (req_in.addr == `OFS_PIN_OUTPUT);
    wire wr_dir_lvl = req_in.wr && (req_in.addr == `OFS_PIN_DIR_LEVEL);
    wire wr_if_bias = req_in.wr && (req_in.addr == `OFS_IF_AMP_BIAS);
    wire wr_drv_bias = req_in.wr && (req_in.addr == `OFS_OUT_DRV_BIAS);
    wire wr_lo_bias = req_in.wr && (req_in.addr == `OFS_LO_AMP_BIAS);
    wire wr_trim = req_in.wr && (req_in.addr == `OFS_DET_TRIM);
    wire wr_mix_pos = req_in.wr && (req_in.addr == `OFS_MIX_BIAS_POS);
    wire wr_mix_neg = req_in.wr && (req_in.addr == `OFS_MIX_BIAS_NEG);

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    logic [7:0] rdata_next;
    always_comb
    begin
        // Unmapped offsets read as zero
        if (req_in.addr == `OFS_CONV_CONTROL)
            rdata_next = control_reg;
        else if (req_in.addr == `OFS_CONV_STATUS)
            rdata_next = status_reg;
        else if (req_in.addr == `OFS_CONV_RESULT)
            rdata_next = result_reg;
        else if (req_in.addr == `OFS_PIN_OUTPUT)
            rdata_next = pin_output_reg;
        else if (req_in.addr == `OFS_PIN_INPUT)
            rdata_next = {4'h0, pin_sampled_reg, 1'b0};
        else if (req_in.addr == `OFS_PIN_DIR_LEVEL)
            rdata_next = pin_dir_level_reg;
        else if (req_in.addr == `OFS_IF_AMP_BIAS)
            rdata_next = if_bias_reg;
        else if (req_in.addr == `OFS_OUT_DRV_BIAS)
            rdata_next = drv_bias_reg;
        else if (req_in.addr == `OFS_LO_AMP_BIAS)
            rdata_next = lo_bias_reg;
        else if (req_in.addr == `OFS_DET_TRIM)
            rdata_next = trim_reg;
        else if (req_in.addr == `OFS_MIX_BIAS_POS)
            rdata_next = mix_pos_reg;
        else if (req_in.addr == `OFS_MIX_BIAS_NEG)
            rdata_next = mix_neg_reg;
        else
            rdata_next = 8'h00;
    end

    // ------------------------------------------------------------
    // Converter control decode
    // ------------------------------------------------------------
    wire [3:0] clk_divider = control_reg[7:4]; // conv_clock_divider
    wire conv_enable = control_reg[`BIT_CONV_ENABLE];
    wire start_bit = control_reg[`BIT_CONV_START];
    // Rising edge of start only, and only when enabled
    wire start_edge = start_bit && !start_prev_reg && conv_enable;
    // Converter clock toggles at end of each divided half period, rising at every second one
    wire div_wrap = ref_tick_in && (div_count_reg + 4'h1 >= clk_divider);
    wire conv_step = div_wrap && !conv_clk_reg;
    // Sample, halved if bit 2 set and log-scaled if bit 3 set, presented as result
    wire [RESULT_W-1:0] halved = control_reg[`BIT_CONV_HALVE] ? (sample_in >> 1)
                                                             : sample_in;
    wire [RESULT_W-1:0] log_val = log_scale(halved);
    wire [7:0] result_next = control_reg[`BIT_CONV_LOG] ? log_val[7:0]
                                                        : halved[7:0];

    // Leading-one position with three fraction bits
    function automatic logic [RESULT_W-1:0] log_scale(input logic [RESULT_W-1:0] x);
        logic [RESULT_W-1:0] res;
        res = '0;
        for (int i = 0; i < RESULT_W; i++)
        begin
            if (x[i])
                res = RESULT_W'((i << 5) | ((i >= 3) ? ((x >> (i - 3)) & 7) << 2 : 0));
        end
        log_scale = res;
    endfunction : log_scale

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            control_reg <= `RST_CONV_CONTROL;
            pin_output_reg <= `RST_PIN_OUTPUT;
            pin_dir_level_reg <= `RST_PIN_DIR_LEVEL;
            if_bias_reg <= `RST_IF_AMP_BIAS;
            drv_bias_reg <= `RST_OUT_DRV_BIAS;
            lo_bias_reg <= `RST_LO_AMP_BIAS;
            trim_reg <= `RST_DET_TRIM;
            mix_pos_reg <= `RST_MIX_BIAS;
            mix_neg_reg <= `RST_MIX_BIAS;
        end
        else if (clk_en_in)
        begin
            if (wr_control)
                control_reg <= req_in.wdata;
            if (wr_pin_out)
                pin_output_reg <= merge(pin_output_reg, req_in.wdata, `MASK_PIN_OUTPUT);
            if (wr_dir_lvl)
                pin_dir_level_reg <= merge(pin_dir_level_reg, req_in.wdata,
                                           `MASK_PIN_DIR_LEVEL);
            if (wr_if_bias)
                if_bias_reg <= merge(if_bias_reg, req_in.wdata, `MASK_IF_AMP_BIAS);
            if (wr_drv_bias)
                drv_bias_reg <= req_in.wdata;
            if (wr_lo_bias)
                lo_bias_reg <= req_in.wdata;
            if (wr_trim)
                trim_reg <= merge(trim_reg, req_in.wdata, `MASK_5BIT);
            if (wr_mix_pos)
                mix_pos_reg <= merge(mix_pos_reg, req_in.wdata, `MASK_5BIT);
            if (wr_mix_neg)
                mix_neg_reg <= merge(mix_neg_reg, req_in.wdata, `MASK_5BIT);
        end
    end

    // ------------------------------------------------------------
    // Converter clock divider
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            div_count_reg <= 4'h0;
            conv_clk_reg <= 1'b0;
        end
        else if (clk_en_in && ref_tick_in)
        begin
            // Toggle every divider ticks: period is twice the divider
            if (div_wrap)
            begin
                div_count_reg <= 4'h0;
                conv_clk_reg <= !conv_clk_reg;
            end
            else
                div_count_reg <= div_count_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_reg <= CONV_IDLE;
            status_reg <= `RST_CONV_STATUS;
            result_reg <= `RST_CONV_RESULT;
            bit_count_reg <= 4'h0;
            start_prev_reg <= 1'b1;
        end
        else if (clk_en_in)
        begin
            start_prev_reg <= start_bit;
            case (state_reg)
                CONV_IDLE:
                begin
                    // Begin on qualified edge only
                    if (start_edge)
                    begin
                        state_reg <= CONV_RUN;
                        bit_count_reg <= `CONV_CYCLES;
                        status_reg <= 8'h02;
                    end
                end
                CONV_RUN:
                begin
                    // Count converter clock rising edges
                    if (conv_step)
                    begin
                        if (bit_count_reg == 4'h1)
                            state_reg <= CONV_DONE;
                        bit_count_reg <= bit_count_reg - 4'h1;
                    end
                end
                CONV_DONE:
                begin
                    // Latch result, flag ready and complete
                    result_reg <= result_next;
                    status_reg <= 8'h05;
                    state_reg <= CONV_IDLE;
                end
                default:
                    state_reg <= CONV_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pins, read data and analog settings
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            pin_sampled_reg <= `RST_PIN_SAMPLED;
            rdata_reg <= 8'h00;
            pin_out <= '0;
        end
        else if (clk_en_in)
        begin
            pin_sampled_reg <= pin_level_in;
            if (req_in.rd)
                rdata_reg <= rdata_next;
            pin_out.value <= pin_output_reg[3:1];
            pin_out.enable <= pin_dir_level_reg[6:4];
            pin_out.low_volt <= pin_dir_level_reg[3:1];
        end
    end

    assign rdata_out = rdata_reg;
    assign conv_log_out = control_reg[`BIT_CONV_LOG];
    assign conv_halve_out = control_reg[`BIT_CONV_HALVE];
    assign conv_clk_out = conv_clk_reg;
    assign if_amp_bias_level_out = if_bias_reg[3:0];
    assign output_driver_bias_out = drv_bias_reg;
    assign lo_amp_bias_out = lo_bias_reg;
    assign detector_trim_value_out = trim_reg[4:0];
    assign mixer_bias_pos_field_out = mix_pos_reg[4:0];
    assign mixer_bias_neg_field_out = mix_neg_reg[4:0];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_edge;
        clk_en_in && state_reg == CONV_IDLE && start_edge;
    endsequence
    sequence s_busy;
        clk_en_in ##1 status_reg[`BIT_STAT_BUSY] && !status_reg[`BIT_STAT_EOC];
    endsequence

    a_start_busy: assert property (s_edge |-> s_busy)
        else $error("start edge did not raise busy");
    a_disabled_idle: assert property (clk_en_in && !conv_enable && state_reg == CONV_IDLE
        |=> state_reg == CONV_IDLE && $stable(status_reg))
        else $error("conversion began while disabled");
    a_held_start: assert property (clk_en_in && start_prev_reg && state_reg == CONV_IDLE
        |=> state_reg == CONV_IDLE)
        else $error("held start bit began a conversion");
    a_done_flags: assert property (clk_en_in && state_reg == CONV_DONE
        |=> status_reg == 8'h05 && result_reg == $past(result_next))
        else $error("completion flags or result wrong");
    a_busy_excl: assert property (status_reg[`BIT_STAT_BUSY]
        |-> !status_reg[`BIT_STAT_READY] && !status_reg[`BIT_STAT_EOC])
        else $error("busy with ready or complete");
    a_div_period: assert property (clk_en_in && div_wrap
        |=> div_count_reg == 4'h0 && conv_clk_reg != $past(conv_clk_reg))
        else $error("converter clock did not toggle");
    a_pin_drive: assert property (clk_en_in
        |=> pin_out.value == $past(pin_output_reg[3:1])
        && pin_out.enable == $past(pin_dir_level_reg[6:4]))
        else $error("pin drive mismatch");
    a_pin_level: assert property (clk_en_in |=> pin_out.low_volt
        == $past(pin_dir_level_reg[3:1]))
        else $error("pin level mismatch");
    a_trim_resv: assert property (trim_reg[7:5] == 3'h0)
        else $error("trim reserved bits set");

endmodule : adc_gpio_bias_regs
`default_nettype wire

// File: verif/host_model.sv
// Host controller model issuing register requests to the bank
`timescale 1ns/10ps
`default_nettype none
module host_model
    import conv_bank_pkg::*;
(
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output var reg_req_s req_out
);
    // No request pending at start
    initial req_out = '0;

    // ----------------
    // Bus cycles
    // ----------------
    // One write strobe, held over one rising edge, then lines scrambled
    task automatic write_reg(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_in);
        req_out.addr = a;
        req_out.wdata = d;
        req_out.wr = 1'b1;
        @(negedge clk_in);
        req_out.wr = 1'b0;
        req_out.addr = ~a;
        req_out.wdata = ~d;
    endtask : write_reg

    // One read strobe; data is taken once the registered answer settles
    task automatic read_reg(input logic [9:0] a, output logic [7:0] d);
        @(negedge clk_in);
        req_out.addr = a;
        req_out.rd = 1'b1;
        @(negedge clk_in);
        req_out.rd = 1'b0;
        req_out.addr = ~a;
        @(negedge clk_in);
        d = rdata_in;
    endtask : read_reg

    // ----------------
    // Host sequences
    // ----------------
    // Start bit low then high gives the triggering edge
    task automatic start_conv(input logic [7:0] ctrl);
        write_reg(10'h302, ctrl & 8'hFD);
        write_reg(10'h302, ctrl | 8'h02);
    endtask : start_conv

    // Advised bias settings for mixer, driver and oscillator amplifiers
    task automatic recommended();
        write_reg(10'h30D, 8'h09);
        write_reg(10'h30E, 8'h09);
        write_reg(10'h309, 8'h00);
        write_reg(10'h30A, 8'h00);
    endtask : recommended
endmodule : host_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking testbench of the converter, pin and bias bank
`timescale 1ns/10ps
`default_nettype none
`define CHECK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top
    import conv_bank_pkg::*;
;
    // Register rows: offset, reset value, readback after writing ones
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] rst;
        logic [7:0] full;
    } reg_row_s;
    reg_row_s rows [13] = '{'{10'h302, 8'hCA, 8'hFF}, '{10'h303, 8'h01, 8'h01},
        '{10'h304, 8'hEF, 8'hEF}, '{10'h305, 8'h00, 8'h0E}, '{10'h306, 8'h0E, 8'h0E},
        '{10'h307, 8'h00, 8'h7E}, '{10'h308, 8'h08, 8'h0F}, '{10'h309, 8'h88, 8'hFF},
        '{10'h30A, 8'h88, 8'hFF}, '{10'h30B, 8'h00, 8'h00}, '{10'h30C, 8'h00, 8'h1F},
        '{10'h30D, 8'h08, 8'h1F}, '{10'h30E, 8'h08, 8'h1F}};
    // Conversion rows: control byte and expected result for sample 0x64
    logic [15:0] conv_rows [3] = '{16'h2164, 16'h2532, 16'h29D0};
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic clk_en_in = 1'b1; // Dropped once to check the freeze
    logic ref_tick_in = 1'b0;
    logic [7:0] sample_in = 8'h64;
    logic [2:0] ext_level = 3'h7; // Level an outside driver puts on pins
    logic [2:0] pin_level_in;
    reg_req_s req;
    logic [7:0] rdata_out;
    pin_drive_s pin_out;
    logic conv_log_out, conv_halve_out, conv_clk_out;
    logic [7:0] drv_bias, lo_bias;
    logic [4:0] det_trim, mix_pos, mix_neg;
    logic [3:0] if_bias;
    logic [7:0] rd;
    int fails = 0;
    int num_checks = 0;
    int n1, n2;

    // 50 MHz clock; reference tick every second cycle
    always #10 clk_in = ~clk_in;
    always @(negedge clk_in) ref_tick_in <= ~ref_tick_in;
    // Driven pins show their value, the others the outside level
    assign pin_level_in = (pin_out.enable & pin_out.value) | (~pin_out.enable & ext_level);

    adc_gpio_bias_regs i_adc_gpio_bias_regs (.clk_in(clk_in), .reset_in(reset_in),
        .clk_en_in(clk_en_in), .req_in(req), .ref_tick_in(ref_tick_in),
        .sample_in(sample_in), .pin_level_in(pin_level_in), .rdata_out(rdata_out),
        .pin_out(pin_out), .conv_log_out(conv_log_out), .conv_halve_out(conv_halve_out),
        .conv_clk_out(conv_clk_out), .if_amp_bias_level_out(if_bias),
        .output_driver_bias_out(drv_bias), .lo_amp_bias_out(lo_bias),
        .detector_trim_value_out(det_trim), .mixer_bias_pos_field_out(mix_pos),
        .mixer_bias_neg_field_out(mix_neg));
    host_model i_host_model (.clk_in(clk_in), .rdata_in(rdata_out), .req_out(req));

    // ----------------
    // Helpers
    // ----------------
    // Read a register and compare
    task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] v;
        i_host_model.read_reg(a, v);
        `CHECK(v, e)
    endtask : rdchk

    // Count falling edges until the converter clock shows a level
    task automatic wait_lvl(input logic l, output int n);
        n = 0;
        while (conv_clk_out !== l && n < 200)
        begin
            @(negedge clk_in);
            n++;
        end
    endtask : wait_lvl

    // Poll status until conversion complete, bounded
    task automatic wait_done();
        int n;
        n = 0;
        rd = 8'h00;
        while (rd[0] !== 1'b1 && n < 100)
        begin
            i_host_model.read_reg(10'h303, rd);
            n++;
        end
    endtask : wait_done

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // ----------------
    // Main sequence
    // ----------------
    initial
    begin
        repeat (4) @(negedge clk_in);
        reset_in = 1'b0;
        foreach (rows[i]) rdchk(rows[i].addr, rows[i].rst);
        foreach (rows[i])
        begin
            i_host_model.write_reg(rows[i].addr, 8'hFF);
            rdchk(rows[i].addr, rows[i].full);
        end
        `CHECK({if_bias, det_trim}, 9'h1FF)
        i_host_model.recommended();
        `CHECK({mix_pos, mix_neg, drv_bias, lo_bias}, 26'h1290000)
        // Pin 1 driven high, pins 1 and 3 outputs, pins 1 and 2 at 1.8 V, pin 2 pulled high
        i_host_model.write_reg(10'h305, 8'h02);
        i_host_model.write_reg(10'h307, 8'h56);
        ext_level = 3'h2;
        // Pad register follows the control write by one cycle
        @(negedge clk_in);
        `CHECK(pin_out, 9'h06B)
        rdchk(10'h306, 8'h06);
        // Converter clock period against divider
        for (int d = 2; d < 4; d++)
        begin
            i_host_model.write_reg(10'h302, {d[3:0], 4'h1});
            wait_lvl(1'b0, n1);
            wait_lvl(1'b1, n1);
            wait_lvl(1'b0, n1);
            wait_lvl(1'b1, n2);
            `CHECK(n1 + n2, 4 * d)
        end
        // Plain, halved and log-scaled conversions
        foreach (conv_rows[i])
        begin
            i_host_model.start_conv(conv_rows[i][15:8]);
            repeat (2) @(negedge clk_in);
            rdchk(10'h303, 8'h02);
            wait_done();
            `CHECK(rd, 8'h05)
            rdchk(10'h304, conv_rows[i][7:0]);
            `CHECK({conv_log_out, conv_halve_out}, conv_rows[i][11:10])
        end
        // Start held high starts nothing more
        i_host_model.write_reg(10'h302, 8'h2B);
        repeat (3) @(negedge clk_in);
        rdchk(10'h303, 8'h05);
        // Start edge while disabled is ignored
        sample_in = 8'h11;
        i_host_model.write_reg(10'h302, 8'h28);
        i_host_model.write_reg(10'h302, 8'h2A);
        repeat (3) @(negedge clk_in);
        rdchk(10'h303, 8'h05);
        rdchk(10'h304, 8'hD0);
        // Write while clock enable is low must not land
        clk_en_in = 1'b0;
        i_host_model.write_reg(10'h30C, 8'h05);
        clk_en_in = 1'b1;
        rdchk(10'h30C, 8'h1F);
        // Reset in mid-run, then enable with start already high
        reset_in = 1'b1;
        @(negedge clk_in);
        `CHECK({rdata_out, pin_out, conv_clk_out}, 18'h0)
        reset_in = 1'b0;
        rdchk(10'h302, 8'hCA);
        i_host_model.write_reg(10'h302, 8'hCB);
        repeat (3) @(negedge clk_in);
        rdchk(10'h303, 8'h01);
        print_verdict();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #400000;
        fails++;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
